/* tlr_defines.svh */
// constants for the trigger line routing and start block
`ifndef TLR_DEFINES_SVH
`define TLR_DEFINES_SVH
`define TLR_NUM_LINES      7
`define TLR_NUM_SIGS       5
`define TLR_SIG_TRIG       3'h0
`define TLR_SIG_WCLK       3'h1
`define TLR_SIG_LOW        3'h2
`define TLR_SIG_SWST       3'h3
`define TLR_SIG_STRX       3'h4
`define TLR_DIR_RX         1'b0
`define TLR_DIR_TX         1'b1
`define TLR_ADR_CMD        4'h0
`define TLR_ADR_CTRL       4'h1
`define TLR_ADR_ROUTE      4'h2
`define TLR_ADR_STAT       4'h3
`define TLR_ADR_LOWREG     4'h4
`define TLR_CMD_CONN       2'h1
`define TLR_CMD_DISC       2'h2
`define TLR_CMD_CLEAR      2'h3
`define TLR_PULSE_NS       32
`define TLR_PULSE_CYC      ((`TLR_PULSE_NS + 7) / 8)
`endif

/* tlr_pkg.sv */
// types for the trigger line routing and start block
`default_nettype none
package tlr_pkg;
    typedef struct packed {
        logic       en;
        logic       dir;
        logic [2:0] line;
    } tlr_route_t;
    typedef enum logic [1:0] {
        TLR_IDLE = 2'b00,
        TLR_POST = 2'b01,
        TLR_PRE  = 2'b10,
        TLR_CNT  = 2'b11
    } tlr_state_t;
endpackage
`default_nettype wire

/* tlr_router.sv */
// trigger line switch with acquisition start and trigger logic
// Notes on behaviour
// - signal codes: 0 trigger, 1 word clock, 2 low, 3 soft start, 4 start receiver
// - fixed low output stays low, level held by an internal register
// - adc word clock can be driven onto a line
// - receiving trigger signal falling edge activates the sample counter
// - posttrigger mode: trigger falling edge begins acquisition
// - pretrigger mode: trigger falling edge begins posttrigger samples
// - trigger signal as source drives the line with local trigger
// - local trigger from external pin or analog detector per enable
// - analog detector gives active low pulse when condition met
// - software trigger gives active low soft start pulse in both modes
// - soft start may feed other boards' start receivers to start together
// - posttrigger: start receiver edge acts like trigger edge
// - pretrigger: start receiver edge starts continuous acquisition only
// - pretrigger: counter idle until line, pin or analog trigger
// - connection needs one transmitter and one or more receivers
// - connections removed singly or all at once
// - after clear all no line driven or received
// - reset leaves interface cleared
// - any signal attaches to any line 0 to 6
// - direction 0 receives, 1 drives
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tlr_defines.svh"
`default_nettype none
module tlr_router
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // shared trigger lines, open drain
    input  wire logic [6:0]  line_i,
    output logic      [6:0]  line_o,
    output logic      [6:0]  line_oe_o,
    // local board signals
    input  wire logic        adc_word_clock_i,
    input  wire logic        external_trigger_pin_n_i,
    input  wire logic        analog_cond_i,
    // acquisition outputs
    output logic             acq_run_o,
    output logic             sample_count_en_o,
    output logic             analog_trig_n_o
);
    localparam int NL = `TLR_NUM_LINES;
    localparam int NS = `TLR_NUM_SIGS;
    localparam logic [2:0] PCYC = 3'(`TLR_PULSE_CYC);

    tlr_pkg::tlr_route_t route_q [NS];
    tlr_pkg::tlr_state_t state_q;
    logic       post_mode_q;
    logic       ext_en_q;
    logic       ana_en_q;
    logic       low_lvl_q;
    logic [2:0] sw_cnt_q;
    logic [2:0] an_cnt_q;
    logic       an_prev_q;
    logic [2:0] ext_s_q;
    logic       ext_st_q;
    logic [2:0] s_trig_q;
    logic [2:0] s_strx_q;
    logic       trig_st_q;
    logic       strx_st_q;
    logic       ack_q;

    // bus access
    logic       wr;
    logic       rd;
    assign wr = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
    assign rd = cyc_i && stb_i && !we_i && !ack_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= cyc_i && stb_i && !ack_q;
    end
    assign ack_o = ack_q;

    // route table with connect, disconnect, clear
    logic       cmd_wr;
    logic [1:0] cmd_op;
    logic [2:0] cmd_sig;
    logic [2:0] cmd_line;
    logic       cmd_dir;
    assign cmd_wr   = wr && adr_i == `TLR_ADR_CMD;
    assign cmd_op   = dat_i[1:0];
    assign cmd_dir  = dat_i[2];
    assign cmd_line = dat_i[6:4];
    assign cmd_sig  = dat_i[10:8];

    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : g_route
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    route_q[g] <= '0;
                else if (cmd_wr && cmd_op == `TLR_CMD_CLEAR)
                    route_q[g] <= '0;
                else if (cmd_wr && cmd_sig == 3'(g) && cmd_line < 3'(NL))
                begin
                    if (cmd_op == `TLR_CMD_CONN)
                        route_q[g] <= '{en: 1'b1, dir: cmd_dir, line: cmd_line};
                    else if (cmd_op == `TLR_CMD_DISC && route_q[g].line == cmd_line)
                        route_q[g] <= '0;
                end
            end
        end
    endgenerate

    // control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            post_mode_q <= 1'b1;
            ext_en_q    <= 1'b1;
            ana_en_q    <= 1'b0;
            low_lvl_q   <= 1'b0;
        end
        else
        begin
            if (wr && adr_i == `TLR_ADR_CTRL)
            begin
                post_mode_q <= dat_i[0];
                ext_en_q    <= dat_i[1];
                ana_en_q    <= dat_i[2];
            end
            low_lvl_q <= 1'b0;
        end
    end

    // software trigger pulse
    logic sw_go;
    assign sw_go = wr && adr_i == `TLR_ADR_CTRL && dat_i[4];
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sw_cnt_q <= '0;
        else if (sw_go)
            sw_cnt_q <= PCYC;
        else if (sw_cnt_q != 3'h0)
            sw_cnt_q <= sw_cnt_q - 3'h1;
    end

    // analog detector pulse on condition rise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            an_cnt_q  <= '0;
            an_prev_q <= 1'b0;
        end
        else
        begin
            an_prev_q <= analog_cond_i;
            if (analog_cond_i && !an_prev_q)
                an_cnt_q <= PCYC;
            else if (an_cnt_q != 3'h0)
                an_cnt_q <= an_cnt_q - 3'h1;
        end
    end
    assign analog_trig_n_o = (an_cnt_q == 3'h0);

    // external pin synchroniser, a change counts when stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_s_q  <= 3'b111;
            ext_st_q <= 1'b1;
        end
        else
        begin
            ext_s_q <= {ext_s_q[1:0], external_trigger_pin_n_i};
            if (ext_s_q[1] == ext_s_q[2])
                ext_st_q <= ext_s_q[2];
        end
    end

    logic local_trig_n;
    logic soft_n;
    always_comb
    begin
        local_trig_n = 1'b1;
        if (ext_en_q)
            local_trig_n = ext_st_q;
        else if (ana_en_q)
            local_trig_n = analog_trig_n_o;
    end
    assign soft_n = (sw_cnt_q == 3'h0);

    // source values per signal code
    logic [NS-1:0] src_val;
    always_comb
    begin
        src_val = '1;
        src_val[`TLR_SIG_TRIG] = local_trig_n;
        src_val[`TLR_SIG_WCLK] = adc_word_clock_i;
        src_val[`TLR_SIG_LOW]  = low_lvl_q;
        src_val[`TLR_SIG_SWST] = soft_n;
    end

    // line drive, open drain: only low levels are driven
    logic [NL-1:0] drv_low;
    always_comb
    begin
        drv_low = '0;
        for (int s = 0; s < NS; s++)
        begin
            if (route_q[s].en && route_q[s].dir == `TLR_DIR_TX && s != 4 && !src_val[s])
                drv_low[route_q[s].line] = 1'b1;
        end
    end
    assign line_o    = '0;
    assign line_oe_o = drv_low;

    // receive: selected line, idle high when unrouted
    logic trig_raw;
    logic strx_raw;
    always_comb
    begin
        trig_raw = 1'b1;
        strx_raw = 1'b1;
        if (route_q[0].en && route_q[0].dir == `TLR_DIR_RX)
            trig_raw = line_i[route_q[0].line];
        if (route_q[4].en && route_q[4].dir == `TLR_DIR_RX)
            strx_raw = line_i[route_q[4].line];
    end

    // received line synchronisers and edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_trig_q  <= 3'b111;
            s_strx_q  <= 3'b111;
            trig_st_q <= 1'b1;
            strx_st_q <= 1'b1;
        end
        else
        begin
            s_trig_q <= {s_trig_q[1:0], trig_raw};
            s_strx_q <= {s_strx_q[1:0], strx_raw};
            if (s_trig_q[1] == s_trig_q[2])
                trig_st_q <= s_trig_q[2];
            if (s_strx_q[1] == s_strx_q[2])
                strx_st_q <= s_strx_q[2];
        end
    end
    logic trig_fall;
    logic strx_fall;
    assign trig_fall = trig_st_q && s_trig_q[1] == s_trig_q[2] && !s_trig_q[2];
    assign strx_fall = strx_st_q && s_strx_q[1] == s_strx_q[2] && !s_strx_q[2];

    // local trigger edge for pretrigger counting
    logic loc_prev_q;
    logic loc_fall;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            loc_prev_q <= 1'b1;
        else
            loc_prev_q <= local_trig_n;
    end
    assign loc_fall = loc_prev_q && !local_trig_n;

    // acquisition sequencing
    logic any_trig;
    assign any_trig = trig_fall || loc_fall;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= tlr_pkg::TLR_IDLE;
        else
        begin
            case (state_q)
                tlr_pkg::TLR_IDLE:
                begin
                    if (post_mode_q && (trig_fall || strx_fall))
                        state_q <= tlr_pkg::TLR_CNT;
                    else if (!post_mode_q && strx_fall)
                        state_q <= tlr_pkg::TLR_PRE;
                end
                tlr_pkg::TLR_PRE:
                begin
                    if (any_trig)
                        state_q <= tlr_pkg::TLR_CNT;
                end
                tlr_pkg::TLR_CNT:
                begin
                    if (wr && adr_i == `TLR_ADR_CTRL && dat_i[5])
                        state_q <= tlr_pkg::TLR_IDLE;
                end
                default:
                    state_q <= tlr_pkg::TLR_IDLE;
            endcase
        end
    end
    assign acq_run_o         = (state_q != tlr_pkg::TLR_IDLE);
    assign sample_count_en_o = (state_q == tlr_pkg::TLR_CNT);

    // read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (rd)
        begin
            case (adr_i)
                `TLR_ADR_CTRL:   dat_o <= {29'h0, ana_en_q, ext_en_q, post_mode_q};
                `TLR_ADR_ROUTE:  dat_o <= {7'h0, route_q[4], route_q[3], route_q[2], route_q[1], route_q[0]};
                `TLR_ADR_STAT:   dat_o <= {22'h0, line_i, sample_count_en_o, acq_run_o, state_q == tlr_pkg::TLR_PRE};
                `TLR_ADR_LOWREG: dat_o <= {31'h0, low_lvl_q};
                default:         dat_o <= 32'h0;
            endcase
        end
    end

    // checks
    clear_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_wr && cmd_op == `TLR_CMD_CLEAR |=> line_oe_o == '0) else $error("line driven after clear");
    reset_clear_a: assert property (@(posedge clk_i)
        rst_i |=> line_oe_o == '0 && !acq_run_o) else $error("not cleared by reset");
    low_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        route_q[2].en && route_q[2].dir == `TLR_DIR_TX |-> line_oe_o[route_q[2].line]) else $error("low not driven");
    soft_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sw_go |=> !soft_n [*4] ##1 soft_n) else $error("soft start pulse length wrong");
    post_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == tlr_pkg::TLR_IDLE && post_mode_q && trig_fall |=> sample_count_en_o)
        else $error("posttrigger start missed");
    pre_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == tlr_pkg::TLR_PRE && !any_trig |=> !sample_count_en_o)
        else $error("counter ran before trigger");
    pre_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == tlr_pkg::TLR_IDLE && !post_mode_q && strx_fall |=> acq_run_o && !sample_count_en_o)
        else $error("pretrigger start wrong");
    edge_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
        trig_fall |-> $past(trig_raw, 2) == 1'b0) else $error("edge without synchronised low");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held two cycles");
    post_cov: cover property (@(posedge clk_i) post_mode_q && trig_fall);
    pre_cov: cover property (@(posedge clk_i) state_q == tlr_pkg::TLR_PRE ##[1:50] sample_count_en_o);
    drive_cov: cover property (@(posedge clk_i) line_oe_o != '0);
endmodule // tlr_router
`default_nettype wire

/* tlr_far_board.sv */
// model of another acquisition board on the shared trigger lines
`timescale 1ns/1ps
`default_nettype none
module tlr_far_board
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // pulse request from the bench
    input  wire logic       go_i,
    input  wire logic [2:0] sel_i,
    // shared lines
    input  wire logic [6:0] line_i,
    output logic      [6:0] oe_o,
    output logic      [6:0] fall_o
);
    logic [2:0] cnt_q;
    logic [2:0] sel_q;
    logic [6:0] prev_q;
    // one four cycle low pulse at a time, on a line the bench keeps free of other sources
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= 3'h0;
        else if (go_i && cnt_q == 3'h0)
            cnt_q <= 3'h4;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    always_ff @(posedge clk_i)
    begin
        if (go_i && cnt_q == 3'h0)
            sel_q <= sel_i;
    end
    assign oe_o = (cnt_q != 3'h0) ? (7'h01 << sel_q) : 7'h00;
    // receiver side: remember every falling edge seen on a line
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_q <= 7'h7F;
            fall_o <= 7'h00;
        end
        else
        begin
            prev_q <= line_i;
            fall_o <= fall_o | (prev_q & ~line_i);
        end
    end
endmodule // tlr_far_board
`default_nettype wire

/* tlr_router_tb_top.sv */
// self-checking bench for the trigger line router
`timescale 1ns/1ps
`include "tlr_defines.svh"
`default_nettype none
module tlr_router_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [3:0]  wsel  = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [6:0]  line_w;
    logic [6:0]  line_o;
    logic [6:0]  line_oe_o;
    logic [6:0]  far_oe;
    logic [6:0]  far_fall;
    logic        wclk  = 1'b0;
    logic        ext_n = 1'b1;
    logic        acond = 1'b0;
    logic        go    = 1'b0;
    logic [2:0]  gsel  = 3'h0;
    logic        run;
    logic        cnt_en;
    logic        atrig_n;
    logic [31:0] exp_route = 32'h0;
    int          fail_count = 0;
    int          checks = 0;
    // open drain lines with pull-up
    assign line_w = ~(line_oe_o | far_oe);
    tlr_router u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .line_i(line_w),
        .line_o(line_o), .line_oe_o(line_oe_o), .adc_word_clock_i(wclk), .external_trigger_pin_n_i(ext_n),
        .analog_cond_i(acond), .acq_run_o(run), .sample_count_en_o(cnt_en), .analog_trig_n_o(atrig_n));
    tlr_far_board u_far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sel_i(gsel), .line_i(line_w),
        .oe_o(far_oe), .fall_o(far_fall));
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= a;
        sel_i <= wsel;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1)
        begin
            fail_count++;
            finish_test();
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        cmp32(r, exp);
    endtask
    task automatic route(input logic [1:0] op, input logic [2:0] sig, input logic dir, input logic [2:0] ln);
        wr(`TLR_ADR_CMD, {21'h0, sig, 1'b0, ln, 1'b0, dir, op});
        if (ln != 3'h7)
            exp_route = (exp_route & ~(32'h1F << (5 * sig)))
                | ((op == `TLR_CMD_CONN) ? ({27'h0, 1'b1, dir, ln} << (5 * sig)) : 32'h0);
        rd_chk(`TLR_ADR_ROUTE, exp_route);
    endtask
    function automatic logic cur(input int i);
        logic [4:0] v;
        v = {line_oe_o[6], far_fall[2], atrig_n, cnt_en, run};
        return v[i];
    endfunction
    task automatic wait_for(input int i, input logic val);
        int n;
        n = 0;
        while (cur(i) !== val && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        cmp1(cur(i), val);
    endtask
    task automatic pulse(input logic [2:0] ln);
        @(posedge clk_i);
        go   <= 1'b1;
        gsel <= ln;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    initial
    begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp32({25'h0, line_oe_o}, 32'h0);
        cmp1(atrig_n, 1'b1);
        cmp32({25'h0, line_o}, 32'h0);
        rd_chk(`TLR_ADR_ROUTE, 32'h0);
        rd_chk(`TLR_ADR_CTRL, 32'h3);
        rd_chk(`TLR_ADR_LOWREG, 32'h0);
        rd_chk(4'hF, 32'h0);
        // a write without its low byte lane selected must leave control alone
        wsel = 4'h0;
        wr(`TLR_ADR_CTRL, 32'h00);
        wsel = 4'hF;
        rd_chk(`TLR_ADR_CTRL, 32'h3);
        route(`TLR_CMD_CONN, `TLR_SIG_SWST, `TLR_DIR_TX, 3'h2);
        wr(`TLR_ADR_CTRL, 32'h13);
        wait_for(3, 1'b1);
        route(`TLR_CMD_CONN, `TLR_SIG_TRIG, `TLR_DIR_RX, 3'h5);
        route(`TLR_CMD_CONN, `TLR_SIG_STRX, `TLR_DIR_RX, 3'h1);
        pulse(3'h5);
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        wr(`TLR_ADR_CTRL, 32'h23);
        wait_for(0, 1'b0);
        pulse(3'h1);
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        wr(`TLR_ADR_CTRL, 32'h22);
        wait_for(0, 1'b0);
        pulse(3'h1);
        wait_for(0, 1'b1);
        cmp1(cnt_en, 1'b0);
        rd_chk(`TLR_ADR_STAT, 32'h3FB);
        pulse(3'h5);
        wait_for(1, 1'b1);
        wr(`TLR_ADR_CTRL, 32'h23);
        route(`TLR_CMD_DISC, `TLR_SIG_TRIG, `TLR_DIR_RX, 3'h5);
        route(`TLR_CMD_CONN, `TLR_SIG_TRIG, `TLR_DIR_TX, 3'h6);
        ext_n <= 1'b0;
        wait_for(4, 1'b1);
        ext_n <= 1'b1;
        wait_for(4, 1'b0);
        wr(`TLR_ADR_CTRL, 32'h05);
        acond <= 1'b1;
        wait_for(2, 1'b0);
        cmp1(line_oe_o[6], 1'b1);
        acond <= 1'b0;
        wait_for(2, 1'b1);
        route(`TLR_CMD_CONN, `TLR_SIG_WCLK, `TLR_DIR_TX, 3'h0);
        for (int k = 0; k < 2; k++)
        begin
            wclk <= ~wclk;
            repeat (2) @(posedge clk_i);
            cmp1(line_w[0], wclk);
        end
        route(`TLR_CMD_CONN, `TLR_SIG_LOW, `TLR_DIR_TX, 3'h3);
        cmp1(line_w[3], 1'b0);
        route(`TLR_CMD_CONN, `TLR_SIG_WCLK, `TLR_DIR_TX, 3'h7);
        wr(`TLR_ADR_CMD, {30'h0, `TLR_CMD_CLEAR});
        exp_route = 32'h0;
        rd_chk(`TLR_ADR_ROUTE, 32'h0);
        cmp32({25'h0, line_oe_o}, 32'h0);
        wr(`TLR_ADR_CTRL, 32'h03);
        pulse(3'h1);
        pulse(3'h5);
        cmp1(run, 1'b0);
        // reset with the acquisition idle must drop a live connection
        route(`TLR_CMD_CONN, `TLR_SIG_LOW, `TLR_DIR_TX, 3'h4);
        cmp1(line_w[4], 1'b0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        exp_route = 32'h0;
        cmp32({25'h0, line_oe_o}, 32'h0);
        rd_chk(`TLR_ADR_ROUTE, 32'h0);
        finish_test();
    end
endmodule // tlr_router_tb_top
`default_nettype wire
